/* verilog/fqp_flash.sv */
`timescale 1ns/1ns
`include "fqp_defs.svh"
module fqp_flash import fqp_pkg::*; #(
  parameter int          ADDR_W   = `FQP_ARRAY_ADDR_W,
  parameter int unsigned PP_CYC   = (`FQP_T_PP_US * 1000) / `FQP_CLK_NS,
  parameter int unsigned SE_CYC   = (`FQP_T_SE_US * 1000) / `FQP_CLK_NS,
  parameter int unsigned BE32_CYC = (`FQP_T_BE32_US * 1000) / `FQP_CLK_NS,
  parameter int unsigned BE64_CYC = (`FQP_T_BE64_US * 1000) / `FQP_CLK_NS
) (
  input  wire logic       clk_sys_in,
  input  wire logic       arst_n_in,
  input  wire logic       spi_clk_in,
  input  wire logic       cs_n_in,
  input  wire logic [3:0] quad_data_lines_in,
  output logic      [3:0] quad_data_lines_out,
  output logic      [3:0] quad_data_lines_oe_n_out,
  input  wire logic       quad_enable_bit_in,
  input  wire logic [3:0] protect_level_bits_in,
  output logic            write_in_progress_flag_out,
  output logic            write_enable_latch_out
);
  localparam int          TW     = 22;
  localparam logic [23:0] AMAX24 = 24'((32'h1 << ADDR_W) - 32'h1);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [7:0] mem  [0:(1 << ADDR_W) - 1];
  logic [7:0] pbuf [0:255];

  fqp_link_s   l_r;
  fqp_link_s   l_nxt;
  fqp_eng_s    e_r;
  fqp_eng_s    e_nxt;
  logic        fresh_r;
  logic [6:0]  stat_sync;
  logic [7:0]  stat_s;
  logic        busy_s;
  logic        cs_s;
  logic        buf_we;
  logic [7:0]  buf_idx;
  logic [7:0]  buf_din;
  logic [7:0]  rd_byte;
  logic [3:0]  drv_en;
  logic [3:0]  drv_val;
  logic        mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]  mem_wd;
  logic        t_load;
  logic [TW-1:0] t_cnt;
  logic        t_done;

  // Protection covers the top of the array, doubling with each level.
  function automatic logic prot_hit(input logic [23:0] a, input logic [3:0] lev);
    logic [31:0] top;
    logic [31:0] sz;
    top = (32'h1 << ADDR_W) - 32'h1;
    sz  = 32'h1 << (5'(`FQP_PROT_BASE_LOG) + {1'b0, lev});
    return (lev != 4'h0) && ((({8'h00, a} | (sz - 32'h1)) & top) == top);
  endfunction

  // --------------------------------------------------------------------------
  // Crossings
  // --------------------------------------------------------------------------
  // Status bits are brought into the link domain for status reads and busy checks.
  fqp_sync #(.W(7)) u_stat_sync (
    .clk_in    (spi_clk_in),
    .arst_n_in (arst_n_in),
    .d_in      ({quad_enable_bit_in, protect_level_bits_in, e_r.write_enable_latch, e_r.busy}),
    .q_out     (stat_sync)
  );
  assign stat_s = {1'b0, stat_sync};
  assign busy_s = stat_s[`FQP_ST_BUSY_BIT];

  // The select level is synchronised, so its idle level equals the flop reset value.
  fqp_sync #(.W(1)) u_cs_sync (
    .clk_in    (clk_sys_in),
    .arst_n_in (arst_n_in),
    .d_in      (~cs_n_in),
    .q_out     (cs_s)
  );

  // --------------------------------------------------------------------------
  // Link domain: frame start and parser
  // --------------------------------------------------------------------------
  // Set while chip select is high, cleared by the first rising clock of a frame.
  always_ff @(posedge spi_clk_in or negedge arst_n_in or posedge cs_n_in) begin
    if (!arst_n_in) begin
      fresh_r <= 1'b1;
    end else if (cs_n_in) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  // Parser: every input bit or nibble is taken on the rising clock.
  always_comb begin
    fqp_link_s   s;
    logic [7:0]  op;
    logic [23:0] sh_n;
    logic [7:0]  wb;
    logic        quad;
    s    = l_r;
    op   = 8'h00;
    sh_n = 24'h000000;
    wb   = 8'h00;
    quad = 1'b0;
    buf_we  = 1'b0;
    buf_idx = 8'h00;
    buf_din = 8'h00;
    if (fresh_r) begin
      s.mask  = '0;
      s.armed = 1'b0;
      s.cnt   = 5'h00;
      s.sh    = 24'h000000;
      s.nib   = 1'b0;
      s.st    = l_r.skip_mode ? FQP_L_ADDR : FQP_L_OP;
      s.cmd   = l_r.skip_mode ? FQP_C_QREAD : FQP_C_NONE;
    end
    quad  = (s.cmd == FQP_C_QREAD) || (s.cmd == FQP_C_PPQ);
    l_nxt = s;
    l_nxt.cnt = s.cnt + 5'h01;
    unique case (s.st)
      FQP_L_IDLE: begin
        l_nxt.cnt = s.cnt;
      end
      FQP_L_OP: begin
        op = {s.sh[6:0], quad_data_lines_in[0]};
        l_nxt.sh = {16'h0000, op};
        if (s.cnt == 5'h07) begin
          l_nxt.cnt = 5'h00;
          l_nxt.st  = FQP_L_IDLE;
          if (!busy_s || op == `FQP_OP_STATUS_READ) begin
            case (op)
              `FQP_OP_LATCH_SET: begin
                l_nxt.armed     = 1'b1;
                l_nxt.armed_cmd = FQP_C_LATCH_SET;
              end
              `FQP_OP_STATUS_READ: l_nxt.st = FQP_L_STAT;
              `FQP_OP_QUAD_READ: begin
                l_nxt.cmd = FQP_C_QREAD;
                l_nxt.st  = FQP_L_ADDR;
              end
              `FQP_OP_PAGE_PROG: begin
                l_nxt.cmd = FQP_C_PP;
                l_nxt.st  = FQP_L_ADDR;
              end
              `FQP_OP_QUAD_PROG_A, `FQP_OP_QUAD_PROG_B: begin
                l_nxt.cmd = FQP_C_PPQ;
                l_nxt.st  = FQP_L_ADDR;
              end
              `FQP_OP_SECTOR_A, `FQP_OP_SECTOR_B: begin
                l_nxt.cmd = FQP_C_SE;
                l_nxt.st  = FQP_L_ADDR;
              end
              `FQP_OP_BLOCK32: begin
                l_nxt.cmd = FQP_C_BE32;
                l_nxt.st  = FQP_L_ADDR;
              end
              `FQP_OP_BLOCK64: begin
                l_nxt.cmd = FQP_C_BE64;
                l_nxt.st  = FQP_L_ADDR;
              end
              default: l_nxt.st = FQP_L_IDLE;
            endcase
          end
        end
      end
      FQP_L_ADDR: begin
        // Quad address: first line three carries the most significant bit.
        sh_n = quad ? {s.sh[19:0], quad_data_lines_in} : {s.sh[22:0], quad_data_lines_in[0]};
        l_nxt.sh = sh_n;
        if (s.cnt == (quad ? 5'h05 : 5'h17)) begin
          l_nxt.cnt  = 5'h00;
          l_nxt.addr = sh_n & AMAX24;
          unique case (s.cmd)
            FQP_C_QREAD: l_nxt.st = FQP_L_MODE;
            FQP_C_PP, FQP_C_PPQ: begin
              l_nxt.st   = FQP_L_WDATA;
              l_nxt.wofs = sh_n[7:0];
            end
            FQP_C_SE, FQP_C_BE32, FQP_C_BE64: begin
              l_nxt.st         = FQP_L_IDLE;
              l_nxt.armed      = 1'b1;
              l_nxt.armed_cmd  = s.cmd;
              l_nxt.armed_addr = sh_n;
            end
            FQP_C_NONE, FQP_C_LATCH_SET: l_nxt.st = FQP_L_IDLE;
          endcase
        end
      end
      FQP_L_MODE: begin
        if (s.cnt == 5'h00) begin
          l_nxt.wbyte = {s.wbyte[3:0], quad_data_lines_in};
        end else begin
          l_nxt.cnt = 5'h00;
          if (busy_s) begin
            l_nxt.st = FQP_L_IDLE;
          end else begin
            l_nxt.skip_mode = (s.wbyte[3:0] == `FQP_MODE_SKIP_NIB);
            l_nxt.st        = FQP_L_DUMMY;
          end
        end
      end
      FQP_L_DUMMY: begin
        if (s.cnt == `FQP_DUMMY_CLKS - 5'h01) begin
          l_nxt.cnt = 5'h00;
          l_nxt.nib = 1'b0;
          l_nxt.st  = FQP_L_RDATA;
        end
      end
      FQP_L_RDATA: begin
        l_nxt.cnt = s.cnt;
        l_nxt.nib = ~s.nib;
        if (s.nib) begin
          l_nxt.addr = (s.addr + 24'h000001) & AMAX24;
        end
      end
      FQP_L_WDATA: begin
        wb = quad ? {s.wbyte[3:0], quad_data_lines_in} : {s.wbyte[6:0], quad_data_lines_in[0]};
        l_nxt.wbyte = wb;
        if (s.cnt == (quad ? 5'h01 : 5'h07)) begin
          l_nxt.cnt          = 5'h00;
          buf_we             = 1'b1;
          buf_idx            = s.wofs;
          buf_din            = wb;
          l_nxt.mask[s.wofs] = 1'b1;
          l_nxt.wofs         = s.wofs + 8'h01;
          l_nxt.armed        = 1'b1;
          l_nxt.armed_cmd    = s.cmd;
          l_nxt.armed_addr   = s.addr;
        end
      end
      FQP_L_STAT: begin
        l_nxt.cnt = s.cnt + 5'h01;
      end
    endcase
  end

  always_ff @(posedge spi_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      l_r <= '{st: FQP_L_IDLE, cmd: FQP_C_NONE, armed_cmd: FQP_C_NONE, default: '0};
    end else begin
      l_r <= l_nxt;
    end
  end

  // Page buffer writes; a later byte at the same offset replaces the earlier one.
  always_ff @(posedge spi_clk_in) begin
    if (buf_we) begin
      pbuf[buf_idx] <= buf_din;
    end
  end

  // --------------------------------------------------------------------------
  // Link domain: output drive on the falling clock
  // --------------------------------------------------------------------------
  assign rd_byte = mem[l_r.addr[ADDR_W-1:0]];

  // Selects what the lines carry after the next falling edge.
  always_comb begin
    drv_en  = 4'h0;
    drv_val = 4'h0;
    if (!fresh_r && l_r.st == FQP_L_RDATA) begin
      drv_en  = 4'hF;
      drv_val = l_r.nib ? rd_byte[3:0] : rd_byte[7:4];
    end else if (!fresh_r && l_r.st == FQP_L_STAT) begin
      drv_en     = 4'h2;
      drv_val[1] = stat_s[3'h7 - l_r.cnt[2:0]];
    end
  end

  // Chip select high releases every line at once.
  always_ff @(negedge spi_clk_in or negedge arst_n_in or posedge cs_n_in) begin
    if (!arst_n_in) begin
      quad_data_lines_out      <= 4'h0;
      quad_data_lines_oe_n_out <= 4'hF;
    end else if (cs_n_in) begin
      quad_data_lines_out      <= 4'h0;
      quad_data_lines_oe_n_out <= 4'hF;
    end else begin
      quad_data_lines_out      <= drv_val;
      quad_data_lines_oe_n_out <= ~drv_en;
    end
  end

  // --------------------------------------------------------------------------
  // System domain: program and erase engine
  // --------------------------------------------------------------------------
  fqp_timer #(.W(TW)) u_timer (
    .clk_in    (clk_sys_in),
    .arst_n_in (arst_n_in),
    .load_in   (t_load),
    .count_in  (t_cnt),
    .done_out  (t_done)
  );

  // Acts on the command record once chip select has risen and sck is still.
  always_comb begin
    logic        cs_rise;
    logic [31:0] sz;
    logic [23:0] a24;
    cs_rise = !cs_s && e_r.cs_q;
    sz      = 32'h0;
    a24     = e_r.base | {7'h00, e_r.idx};
    e_nxt      = e_r;
    e_nxt.cs_q = cs_s;
    mem_we  = 1'b0;
    mem_wa  = a24[ADDR_W-1:0];
    mem_wd  = 8'hFF;
    t_load  = 1'b0;
    t_cnt   = '0;
    unique case (e_r.st)
      FQP_E_IDLE: begin
        if (cs_rise && l_r.armed) begin
          unique case (l_r.armed_cmd)
            FQP_C_LATCH_SET: e_nxt.write_enable_latch = 1'b1;
            FQP_C_PP, FQP_C_PPQ: begin
              if (e_r.write_enable_latch && !prot_hit(l_r.armed_addr, protect_level_bits_in)
                  && (l_r.armed_cmd == FQP_C_PP || quad_enable_bit_in)) begin
                e_nxt.st   = FQP_E_PROG;
                e_nxt.busy = 1'b1;
                e_nxt.base = {l_r.armed_addr[23:8], 8'h00};
                e_nxt.idx  = 17'h00000;
                e_nxt.last = 17'h000FF;
                t_load     = 1'b1;
                t_cnt      = TW'(PP_CYC);
              end
            end
            FQP_C_SE, FQP_C_BE32, FQP_C_BE64: begin
              if (l_r.armed_cmd == FQP_C_SE) begin
                sz    = 32'h1 << `FQP_SECTOR_LOG;
                t_cnt = TW'(SE_CYC);
              end else if (l_r.armed_cmd == FQP_C_BE32) begin
                sz    = 32'h1 << `FQP_BLOCK32_LOG;
                t_cnt = TW'(BE32_CYC);
              end else begin
                sz    = 32'h1 << `FQP_BLOCK64_LOG;
                t_cnt = TW'(BE64_CYC);
              end
              if (e_r.write_enable_latch && !prot_hit(l_r.armed_addr, protect_level_bits_in)) begin
                e_nxt.st   = FQP_E_ERASE;
                e_nxt.busy = 1'b1;
                e_nxt.base = l_r.armed_addr & ~(sz[23:0] - 24'h000001);
                e_nxt.idx  = 17'h00000;
                e_nxt.last = 17'(sz - 32'h1);
                t_load     = 1'b1;
              end
            end
            FQP_C_NONE, FQP_C_QREAD: e_nxt.st = FQP_E_IDLE;
          endcase
        end
      end
      FQP_E_PROG: begin
        // Only offsets that received data are touched, and only toward zero.
        mem_we = l_r.mask[e_r.idx[7:0]];
        mem_wd = mem[mem_wa] & pbuf[e_r.idx[7:0]];
        e_nxt.idx = e_r.idx + 17'h00001;
        if (e_r.idx == e_r.last) begin
          e_nxt.st = FQP_E_WAIT;
        end
      end
      FQP_E_ERASE: begin
        mem_we    = 1'b1;
        e_nxt.idx = e_r.idx + 17'h00001;
        if (e_r.idx == e_r.last) begin
          e_nxt.st = FQP_E_WAIT;
        end
      end
      FQP_E_WAIT: begin
        if (t_done) begin
          e_nxt.st   = FQP_E_IDLE;
          e_nxt.busy = 1'b0;
          e_nxt.write_enable_latch  = 1'b0;
        end
      end
    endcase
  end

  // Latch clear at reset leaves the part write protected.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      e_r <= '{st: FQP_E_IDLE, cs_q: 1'b0, default: '0};
    end else begin
      e_r <= e_nxt;
    end
  end

  // Array writes come only from the engine.
  always_ff @(posedge clk_sys_in) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign write_in_progress_flag_out = e_r.busy;
  assign write_enable_latch_out     = e_r.write_enable_latch;
endmodule // fqp_flash

/* verilog/fqp_defs.svh */
`ifndef FQP_DEFS_SVH
`define FQP_DEFS_SVH

// ----------------------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------------------
`define FQP_OP_LATCH_SET    8'h06
`define FQP_OP_STATUS_READ  8'h05
`define FQP_OP_QUAD_READ    8'hEB
`define FQP_OP_PAGE_PROG    8'h02
`define FQP_OP_QUAD_PROG_A  8'h32
`define FQP_OP_QUAD_PROG_B  8'h38
`define FQP_OP_SECTOR_A     8'hD7
`define FQP_OP_SECTOR_B     8'h20
`define FQP_OP_BLOCK32      8'h52
`define FQP_OP_BLOCK64      8'hD8

// ----------------------------------------------------------------------------
// Frame layout and array geometry
// ----------------------------------------------------------------------------
`define FQP_MODE_SKIP_NIB   4'hA
`define FQP_DUMMY_CLKS      5'h04
`define FQP_ARRAY_ADDR_W    22
`define FQP_SECTOR_LOG      12
`define FQP_BLOCK32_LOG     15
`define FQP_BLOCK64_LOG     16
`define FQP_PROT_BASE_LOG   15

// ----------------------------------------------------------------------------
// Status byte field positions
// ----------------------------------------------------------------------------
`define FQP_ST_BUSY_BIT     0
`define FQP_ST_WEL_BIT      1
`define FQP_ST_PROT_LSB     2
`define FQP_ST_QE_BIT       6

// ----------------------------------------------------------------------------
// Self-timed cycle durations and system clock period
// ----------------------------------------------------------------------------
`define FQP_CLK_NS          50
`define FQP_T_PP_US         700
`define FQP_T_SE_US         45000
`define FQP_T_BE32_US       80000
`define FQP_T_BE64_US       100000

`endif

/* verilog/fqp_pkg.sv */
package fqp_pkg;

  // Decoded command of the current frame.
  typedef enum logic [3:0] {
    FQP_C_NONE, FQP_C_LATCH_SET, FQP_C_QREAD, FQP_C_PP, FQP_C_PPQ, FQP_C_SE, FQP_C_BE32, FQP_C_BE64
  } fqp_cmd_e;

  // Link-side frame parser states.
  typedef enum logic [2:0] {
    FQP_L_IDLE, FQP_L_OP, FQP_L_ADDR, FQP_L_MODE, FQP_L_DUMMY, FQP_L_RDATA, FQP_L_WDATA, FQP_L_STAT
  } fqp_lstate_e;

  // System-side program and erase engine states.
  typedef enum logic [1:0] {
    FQP_E_IDLE, FQP_E_PROG, FQP_E_ERASE, FQP_E_WAIT
  } fqp_estate_e;

  typedef struct packed {
    fqp_lstate_e  st;
    logic [4:0]   cnt;
    fqp_cmd_e     cmd;
    logic [23:0]  sh;
    logic [23:0]  addr;
    logic [7:0]   wofs;
    logic [7:0]   wbyte;
    logic         nib;
    logic [255:0] mask;
    logic         skip_mode;
    logic         armed;
    fqp_cmd_e     armed_cmd;
    logic [23:0]  armed_addr;
  } fqp_link_s;

  typedef struct packed {
    fqp_estate_e  st;
    logic         busy;
    logic         write_enable_latch;
    logic         cs_q;
    logic [23:0]  base;
    logic [16:0]  idx;
    logic [16:0]  last;
  } fqp_eng_s;

endpackage

/* verilog/fqp_sync.sv */
`timescale 1ns/1ns
// Two-stage synchroniser for a bundle of slowly changing levels.
module fqp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d_in;
      q_r    <= meta_r;
    end
  end

  assign q_out = q_r;
endmodule // fqp_sync

/* verilog/fqp_timer.sv */
`timescale 1ns/1ns
// Down counter that times the internal program and erase cycles.
module fqp_timer #(
  parameter int W = 22
) (
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  output logic              done_out
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Load wins; otherwise count down to zero and rest there.
  always_comb begin
    cnt_nxt = cnt_r;
    if (load_in) begin
      cnt_nxt = count_in;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_out = (cnt_r == '0);
endmodule // fqp_timer

/* dv/fqp_chk.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------------
module fqp_chk (
  input wire logic       clk_sys_in,
  input wire logic       arst_n_in,
  input wire logic       cs_n_in,
  input wire logic [3:0] quad_data_lines_oe_n_out,
  input wire logic       write_in_progress_flag_out,
  input wire logic       write_enable_latch_out
);
  // Short aliases for the watched outputs.
  wire logic [3:0] oe_n = quad_data_lines_oe_n_out;
  wire logic       write_in_progress_flag  = write_in_progress_flag_out;
  wire logic       write_enable_latch  = write_enable_latch_out;
  // All checks use the system clock and rest during reset.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  a_cs_release: assert property (cs_n_in |-> oe_n == 4'hF)
    else $error("lines driven while deselected");
  a_oe_shape: assert property ((oe_n == 4'hF) || (oe_n == 4'h0) || (oe_n == 4'hD))
    else $error("unexpected set of driven lines");
  a_latch_on_cs: assert property ($rose(write_enable_latch) |-> cs_n_in)
    else $error("latch set inside a frame");
  a_busy_start: assert property ($rose(write_in_progress_flag) |-> cs_n_in && $past(write_enable_latch))
    else $error("cycle started without latch or frame end");
  a_latch_done: assert property ($fell(write_in_progress_flag) |-> ##[0:2] !write_enable_latch)
    else $error("latch kept after cycle end");
  a_busy_hold: assert property ($rose(write_in_progress_flag) |-> write_in_progress_flag[*8])
    else $error("busy flag too short");
  a_no_read_busy: assert property (write_in_progress_flag |-> oe_n != 4'h0)
    else $error("read data driven while busy");
  a_reset_clear: assert property ($rose(arst_n_in) |-> !write_enable_latch && !write_in_progress_flag)
    else $error("flags set after reset");
endmodule // fqp_chk

bind fqp_flash fqp_chk u_chk (
  .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .cs_n_in(cs_n_in),
  .quad_data_lines_oe_n_out(quad_data_lines_oe_n_out),
  .write_in_progress_flag_out(write_in_progress_flag_out),
  .write_enable_latch_out(write_enable_latch_out)
);

/* dv/fqp_host.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Host controller model, clock still between frames
// ----------------------------------------------------------------------------
module fqp_host (
  input  wire logic [3:0] line_in,
  output logic            sck_out,
  output logic            cs_n_out,
  output logic      [3:0] d_out,
  output logic      [3:0] oe_out
);
  // Idle state: deselected, clock low, lines released.
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    d_out = 4'h0;
    oe_out = 4'h0;
  end
  // One clock: drive while low, sample at the rising edge.
  task automatic unit(input logic [3:0] d, input logic [3:0] oe, output logic [3:0] q);
    d_out = d;
    oe_out = oe;
    #40 sck_out = 1'b1;
    q = line_in;
    #40 sck_out = 1'b0;
  endtask
  // Opens or closes a frame; the gap keeps chip select high long enough.
  task automatic frame(input logic open);
    #40 cs_n_out = !open;
    oe_out = 4'h0;
    #400;
  endtask
  // Sends n bits on line 0 or n nibbles on all lines, most significant first.
  task automatic put(input logic [31:0] v, input int n, input logic quad);
    logic [3:0] q;
    for (int i = n - 1; i >= 0; i--) begin
      if (quad) unit(v[4*i+:4], 4'hF, q);
      else unit({3'h0, v[i]}, 4'h1, q);
    end
  endtask
  // Releases all lines and collects n nibbles.
  task automatic get(input int n, output logic [31:0] v);
    logic [3:0] q;
    v = '0;
    for (int i = 0; i < n; i++) begin
      unit(4'h0, 4'h0, q);
      v = {v[27:0], q};
    end
  endtask
endmodule // fqp_host

/* dv/tb.sv */
`timescale 1ns/1ns
module tb;
  logic        clk_sys, arst_n, qe, seen;
  logic  [3:0] prot, rel;
  logic [31:0] v;
  logic  [7:0] st;
  int          num_errors, comparisons;
  wire logic   sck, cs_n, write_in_progress_flag, write_enable_latch;
  wire logic [3:0] lines, dout, oe_n, h_d, h_oe;
  // Program rows: op, {latch, qe, busy, check}, protect, address, data, expected byte.
  logic [55:0] rows [7] = '{56'h02_F_0_000000_F1_F1, 56'h02_F_0_000000_9F_91, 56'h02_5_0_000020_00_FF,
    56'h32_F_0_000030_5A_5A, 56'h38_9_0_000040_00_FF, 56'h38_F_0_000041_69_69, 56'h02_C_1_010000_00_00};
  // Line level: device, else host, else a pattern that changes every clock.
  assign lines = (~oe_n & dout) | (oe_n & h_oe & h_d) | (oe_n & ~h_oe & rel);
  always @(posedge sck) rel <= ~rel;
  // Notes any drive other than the status line.
  always @(posedge clk_sys) if (oe_n !== 4'hF && oe_n !== 4'hD) seen <= 1'b1;
  fqp_flash #(.ADDR_W(17), .PP_CYC(300), .SE_CYC(5000), .BE32_CYC(35000), .BE64_CYC(70000)) uut (
    .clk_sys_in                 (clk_sys),
    .arst_n_in                  (arst_n),
    .spi_clk_in                 (sck),
    .cs_n_in                    (cs_n),
    .quad_data_lines_in         (lines),
    .quad_data_lines_out        (dout),
    .quad_data_lines_oe_n_out   (oe_n),
    .quad_enable_bit_in         (qe),
    .protect_level_bits_in      (prot),
    .write_in_progress_flag_out (write_in_progress_flag),
    .write_enable_latch_out     (write_enable_latch)
  );
  fqp_host u_host (
    .line_in  (lines),
    .sck_out  (sck),
    .cs_n_out (cs_n),
    .d_out    (h_d),
    .oe_out   (h_oe)
  );
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("Error %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic final_report;
    $display("Checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cfg(input logic q, input logic [3:0] p);
    @(negedge clk_sys);
    qe = q;
    prot = p;
  endtask
  task automatic latch_set_cmd;
    u_host.frame(1'b1);
    u_host.put(32'h06, 8, 1'b0);
    u_host.frame(1'b0);
  endtask
  // Program frame of n bytes; with n of zero it is an erase frame.
  task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n, input logic [7:0] b);
    logic q;
    q = (op == 8'h32 || op == 8'h38);
    u_host.frame(1'b1);
    u_host.put({24'h0, op}, 8, 1'b0);
    u_host.put({8'h0, a}, q ? 6 : 24, q);
    for (int i = 0; i < n; i++) u_host.put({24'h0, 8'((i >> 1) + b)}, q ? 2 : 8, q);
    u_host.frame(1'b0);
  endtask
  task automatic qread(input logic [23:0] a, input logic [7:0] m, input logic skip, input int n);
    u_host.frame(1'b1);
    if (!skip) u_host.put(32'hEB, 8, 1'b0);
    u_host.put({8'h0, a}, 6, 1'b1);
    u_host.put({24'h0, m}, 2, 1'b1);
    u_host.get(4, v);
    u_host.get(2 * n, v);
    u_host.frame(1'b0);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 40000 && write_in_progress_flag !== 1'b0; i++) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #4000000;
    num_errors++;
    final_report();
  end
  initial begin
    {arst_n, qe, prot, rel, seen, num_errors, comparisons} = '0;
    repeat (5) @(negedge clk_sys);
    arst_n = 1'b1;
    chk({write_enable_latch, write_in_progress_flag, oe_n}, 6'h0F);
    cfg(1'b1, 4'h0);
    latch_set_cmd();
    prog(8'h20, 24'h000123, 0, 8'h00);
    wait_idle();
    chk(write_enable_latch, 1'b0);
    foreach (rows[k]) begin
      cfg(rows[k][46], rows[k][43:40]);
      if (rows[k][47]) latch_set_cmd();
      prog(rows[k][55:48], rows[k][39:16], 1, rows[k][15:8]);
      repeat (4) @(negedge clk_sys);
      chk(write_in_progress_flag, rows[k][45]);
      wait_idle();
      if (rows[k][45]) chk(write_enable_latch, 1'b0);
      if (rows[k][44]) qread(rows[k][39:16], 8'h00, 1'b0, 1);
      if (rows[k][44]) chk(v[7:0], rows[k][7:0]);
      $display("Test row %0d done", k);
    end
    cfg(1'b1, 4'h0);
    qread(24'h000030, 8'hA5, 1'b0, 1);
    qread(24'h000041, 8'h00, 1'b1, 1);
    chk(v[7:0], 8'h69);
    qread(24'h000000, 8'h00, 1'b0, 1);
    chk(v[7:0], 8'h91);
    qread(24'h01FFFF, 8'h00, 1'b0, 2);
    chk(v[7:0], 8'h91);
    $display("Test read modes done");
    latch_set_cmd();
    prog(8'h32, 24'h0001FF, 258, 8'h00);
    wait_idle();
    qread(24'h0001FF, 8'h00, 1'b0, 2);
    chk(v[15:0], 16'h80FF);
    qread(24'h000100, 8'h00, 1'b0, 2);
    chk(v[15:0], 16'h8001);
    $display("Test page wrap done");
    latch_set_cmd();
    prog(8'hD7, 24'h001ABC, 0, 8'h00);
    seen = 1'b0;
    qread(24'h000000, 8'h00, 1'b0, 1);
    chk({seen, write_in_progress_flag}, 2'b01);
    u_host.frame(1'b1);
    u_host.put(32'h05, 8, 1'b0);
    u_host.get(8, v);
    u_host.frame(1'b0);
    for (int j = 0; j < 8; j++) st[j] = v[4 * j + 1];
    chk(st, 8'h43);
    wait_idle();
    chk(write_enable_latch, 1'b0);
    qread(24'h001000, 8'h00, 1'b0, 1);
    chk(v[7:0], 8'hFF);
    qread(24'h001FFF, 8'h00, 1'b0, 1);
    chk(v[7:0], 8'hFF);
    $display("Test erase while busy done");
    prog(8'hD8, 24'h000000, 0, 8'h00);
    repeat (4) @(negedge clk_sys);
    chk(write_in_progress_flag, 1'b0);
    latch_set_cmd();
    prog(8'h52, 24'h004321, 0, 8'h00);
    repeat (4) @(negedge clk_sys);
    chk(write_in_progress_flag, 1'b1);
    wait_idle();
    chk(write_enable_latch, 1'b0);
    qread(24'h000000, 8'h00, 1'b0, 1);
    chk(v[7:0], 8'hFF);
    $display("Test block erase done");
    latch_set_cmd();
    u_host.frame(1'b1);
    u_host.put(32'h02000050, 32, 1'b0);
    u_host.put(32'h00, 8, 1'b0);
    repeat (20) @(negedge clk_sys);
    chk(write_in_progress_flag, 1'b0);
    arst_n = 1'b0;
    u_host.frame(1'b0);
    repeat (5) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk({write_enable_latch, write_in_progress_flag}, 2'b00);
    qread(24'h000050, 8'h00, 1'b0, 1);
    chk(v[7:0], 8'hFF);
    $display("Test reset in frame done");
    final_report();
  end
endmodule // tb
